// File: logic/fault_retry_pin_config.v
// fault restart sequencer, spare pin configuration and remote control threshold
`timescale 1ns/10ps
`default_nettype none
`include "fault_retry_pin_config_defines.vh"

module fault_retry_pin_config #(
	parameter [31:0] UNIT_1MS_CYC = (`UNIT_1MS_US / 10) * (`CLK_HZ / 100000),
	parameter [31:0] UNIT_10MS_CYC = (`UNIT_10MS_US / 10) * (`CLK_HZ / 100000),
	parameter [31:0] UNIT_100MS_CYC = (`UNIT_100MS_US / 10) * (`CLK_HZ / 100000),
	parameter [31:0] UNIT_1S_CYC = (`UNIT_1S_US / 10) * (`CLK_HZ / 100000)
) (
	input wire mclk,
	input wire rst,
	input wire cmdWrite,
	input wire cmdRead,
	input wire [7:0] cmdCode,
	input wire [15:0] cmdWrData,
	output reg [15:0] rdData_ff,
	output reg rdValid_ff,
	input wire [1:0] unitSelect,
	input wire faultIn,
	input wire statusClear,
	input wire clearFaults,
	input wire operationOn,
	input wire biasGood,
	input wire otherShutdown,
	output reg outputEnable_ff,
	output reg faultLatched_ff,
	output reg [2:0] attemptCount_ff,
	input wire [7:0] funcPinOut,
	input wire [7:0] funcPinOe,
	input wire [7:0] pinIn,
	output reg [7:0] pinOut_ff,
	output reg [7:0] pinOe_ff,
	output reg [7:0] funcPinIn_ff,
	output reg [7:0] pinUnused_ff,
	input wire rcFromAnalog,
	input wire [7:0] analogLevel,
	output reg remoteTrip_ff
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	localparam ST_RUN = 2'h0;
	localparam ST_RIDE = 2'h1;
	localparam ST_WAIT = 2'h2;
	localparam ST_HOLD = 2'h3;

	// cycles in one delay unit; the unit select comes from outside
	function [31:0] unitCycles;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: unitCycles = UNIT_1MS_CYC;
				2'h1: unitCycles = UNIT_10MS_CYC;
				2'h2: unitCycles = UNIT_100MS_CYC;
				default: unitCycles = UNIT_1S_CYC;
			endcase
		end
	endfunction

	// power-of-two decode of the delay field
	function [7:0] delayUnits;
		input [2:0] field;
		begin
			delayUnits = 8'h01 << field; // R5
		end
	endfunction

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	reg [7:0] respCfg_ff;
	reg [15:0] pinCfg_ff;
	reg [7:0] rcThreshold_ff;

	// writes by command code; unknown codes are ignored
	always @(posedge mclk) begin
		if (rst) begin
			respCfg_ff <= `RESP_RESET;
			pinCfg_ff <= `PIN_CONFIG_RESET;
			rcThreshold_ff <= `RC_THRESHOLD_RESET;
		end else if (cmdWrite) begin
			case (cmdCode)
				`CMD_OV_WARN_RESPONSE: respCfg_ff <= cmdWrData[7:0];
				`CMD_SPARE_PIN_CONFIG: pinCfg_ff <= cmdWrData; // R8
				`CMD_RC_THRESHOLD: rcThreshold_ff <= cmdWrData[7:0]; // R13
				default: respCfg_ff <= respCfg_ff;
			endcase
		end
	end

	// reads answer one cycle later; unknown codes read as zero
	always @(posedge mclk) begin
		if (rst) begin
			rdData_ff <= 16'h0000;
			rdValid_ff <= 1'b0;
		end else begin
			rdValid_ff <= cmdRead;
			if (cmdRead) begin
				case (cmdCode)
					`CMD_OV_WARN_RESPONSE: rdData_ff <= {8'h00, respCfg_ff};
					`CMD_SPARE_PIN_CONFIG: rdData_ff <= pinCfg_ff;
					`CMD_RC_THRESHOLD: rdData_ff <= {8'h00, rcThreshold_ff};
					default: rdData_ff <= 16'h0000;
				endcase
			end
		end
	end

	wire [1:0] respMode = respCfg_ff[`RESP_MODE_HI:`RESP_MODE_LO];
	wire [2:0] retrySet = respCfg_ff[`RESP_RETRY_HI:`RESP_RETRY_LO];
	wire [2:0] delayField = respCfg_ff[`RESP_DELAY_HI:`RESP_DELAY_LO];

	// ------------------------------------------------------------
	// delay timer
	// ------------------------------------------------------------
	reg [31:0] preCnt_ff;
	reg [7:0] unitCnt_ff;
	reg timerRun_ff;
	wire unitTick = timerRun_ff && (preCnt_ff == unitCycles(unitSelect) - 32'h1); // R7
	wire timerDone = unitTick && (unitCnt_ff == delayUnits(delayField) - 8'h01); // R4 R6

	// ------------------------------------------------------------
	// restart sequencer
	// ------------------------------------------------------------
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg nxt_timerRun;
	reg nxt_enable;
	reg nxt_latched;
	reg [2:0] nxt_attempt;
	reg operationSeen_ff;

	// off-to-on is detected by the previous command level
	wire turnOff = !operationOn || !biasGood;
	wire clearReq = statusClear || clearFaults || (operationOn && !operationSeen_ff); // R17
	// forever mode never hits the bound, so the counter may saturate freely
	wire attemptsLeft = (retrySet == `RETRY_FOREVER) || (attemptCount_ff < retrySet); // R1 R2 R3 R16 R18

	always @* begin
		nxt_state = state_ff;
		nxt_timerRun = timerRun_ff;
		nxt_enable = outputEnable_ff;
		nxt_latched = faultLatched_ff;
		nxt_attempt = attemptCount_ff;
		if (turnOff) begin
			// turn-off or bias loss ends every sequence and resets the count
			nxt_state = ST_RUN; // R3 R17
			nxt_timerRun = 1'b0;
			nxt_enable = 1'b0;
			nxt_latched = 1'b0;
			nxt_attempt = 3'h0; // R18
		end else if (otherShutdown) begin
			nxt_state = ST_HOLD; // R3
			nxt_timerRun = 1'b0;
			nxt_enable = 1'b0;
			nxt_latched = 1'b1;
		end else if (clearReq) begin
			nxt_state = ST_RUN; // R17
			nxt_timerRun = 1'b0;
			nxt_enable = 1'b1;
			nxt_latched = 1'b0;
			nxt_attempt = 3'h0; // R18
		end else begin
			case (state_ff)
				ST_RUN: begin
					nxt_enable = 1'b1;
					if (faultIn) begin
						case (respMode) // R14
							`MODE_RIDE: begin
								nxt_state = ST_RIDE;
								nxt_timerRun = 1'b1;
							end
							`MODE_DISABLE_RETRY: begin
								nxt_enable = 1'b0;
								if (retrySet != `RETRY_NONE && attemptsLeft) begin
									nxt_state = ST_WAIT;
									nxt_timerRun = 1'b1;
								end else begin
									nxt_state = ST_HOLD; // R15
									nxt_latched = 1'b1;
								end
							end
							`MODE_LATCH_OFF: begin
								nxt_enable = 1'b0;
								nxt_state = ST_HOLD;
								nxt_latched = 1'b1;
							end
							default: nxt_state = ST_RUN;
						endcase
					end
				end
				ST_RIDE: begin
					// output stays on while the ride-through runs
					if (timerDone) begin
						nxt_timerRun = 1'b0;
						if (!faultIn) begin
							nxt_state = ST_RUN;
						end else if (retrySet != `RETRY_NONE && attemptsLeft) begin
							nxt_enable = 1'b0;
							nxt_state = ST_WAIT; // R6
							nxt_timerRun = 1'b1;
						end else begin
							nxt_enable = 1'b0;
							nxt_state = ST_HOLD; // R15
							nxt_latched = 1'b1;
						end
					end
				end
				ST_WAIT: begin
					if (timerDone) begin
						nxt_timerRun = 1'b0;
						nxt_enable = 1'b1;
						nxt_state = ST_RUN; // R4
						if (attemptCount_ff != 3'h7) begin
							nxt_attempt = attemptCount_ff + 3'h1; // R18
						end
					end
				end
				ST_HOLD: begin
					nxt_enable = 1'b0; // R1 R2 R16
				end
				default: nxt_state = ST_HOLD;
			endcase
		end
	end

	// sequencer and timer registers
	always @(posedge mclk) begin
		if (rst) begin
			state_ff <= ST_RUN;
			timerRun_ff <= 1'b0;
			outputEnable_ff <= 1'b0;
			faultLatched_ff <= 1'b0;
			attemptCount_ff <= 3'h0;
			operationSeen_ff <= 1'b0;
			preCnt_ff <= 32'h0;
			unitCnt_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			timerRun_ff <= nxt_timerRun;
			outputEnable_ff <= nxt_enable;
			faultLatched_ff <= nxt_latched;
			attemptCount_ff <= nxt_attempt;
			operationSeen_ff <= operationOn;
			// timer restarts from zero whenever it is newly started
			if (!timerRun_ff || !nxt_timerRun || timerDone) begin
				preCnt_ff <= 32'h0;
				unitCnt_ff <= 8'h00;
			end else if (unitTick) begin
				preCnt_ff <= 32'h0;
				unitCnt_ff <= unitCnt_ff + 8'h01;
			end else begin
				preCnt_ff <= preCnt_ff + 32'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// spare pins
	// ------------------------------------------------------------
	// order of bits 7..0: second_fault_pin, tms, tdi, tdo, pwm_channel3_b_pin,
	// pwm_channel3_a_pin, pwm_channel2_b_pin, external_adc_trigger_pin
	reg [7:0] pinSyncA_ff;
	reg [7:0] pinSyncB_ff;
	integer i;

	// unused pins ignore their function logic entirely
	always @(posedge mclk) begin
		if (rst) begin
			pinSyncA_ff <= 8'h00;
			pinSyncB_ff <= 8'h00;
			pinOut_ff <= 8'h00;
			pinOe_ff <= 8'h00;
			funcPinIn_ff <= 8'h00;
			pinUnused_ff <= 8'h00;
		end else begin
			pinSyncA_ff <= pinIn;
			pinSyncB_ff <= pinSyncA_ff;
			pinUnused_ff <= pinCfg_ff[7:0]; // R8
			for (i = 0; i < 8; i = i + 1) begin
				if (pinCfg_ff[i]) begin
					pinOut_ff[i] <= 1'b0; // R11
					pinOe_ff[i] <= pinCfg_ff[i + 8]; // R9 R10
					funcPinIn_ff[i] <= 1'b0; // R11
				end else begin
					pinOut_ff[i] <= funcPinOut[i];
					pinOe_ff[i] <= funcPinOe[i];
					funcPinIn_ff[i] <= pinSyncB_ff[i];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// remote control compare
	// ------------------------------------------------------------
	// trip at or above the threshold; no hysteresis is applied here
	always @(posedge mclk) begin
		if (rst) begin
			remoteTrip_ff <= 1'b0;
		end else begin
			remoteTrip_ff <= rcFromAnalog && (analogLevel >= rcThreshold_ff); // R13
		end
	end

endmodule // fault_retry_pin_config
`default_nettype wire

// File: logic/fault_retry_pin_config_defines.vh
// constants for the fault retry and spare pin configuration block
//
// Contract
// R1: retry field 101 gives five restart attempts, then output stays off until cleared.
// R2: retry field 110 gives six restart attempts, then output stays off until cleared.
// R3: retry field 111 retries forever until turn-off, bias loss or shutdown fault.
// R4: restart attempts are spaced by the delay count times the category time unit.
// R5: delay field decodes as two to the power of its value, 1 to 128.
// R6: the same delay serves for ride-through time and for restart spacing.
// R7: the unit length comes from the response-unit configuration, not this register.
// R8: each spare pin has a utilization bit, 0 used and 1 unused.
// R9: upper byte sets each unused pin as input (0) or driven low (1).
// R10: bits 15:8 and 7:0 share one pin order, second fault pin first.
// R11: an unused marking overrides every other function assigned to the pin.
// R12: host should pick output-low for unused pins that are not grounded.
// R13: hold an 8-bit remote control threshold compared against the analog input.
// R14: response field 7:6 selects ignore, ride-through, disable-and-retry or latch off.
// R15: retry field 000 means no restart; output stays off until cleared.
// R16: retry fields 001 to 100 give one to four attempts, then stay off.
// R17: a latched fault clears on status clear, clear command, reset, off-on or bias loss.
// R18: an attempt counter resets on clear or turn-off and bounds the retries.
`ifndef FAULT_RETRY_PIN_CONFIG_DEFINES_VH
`define FAULT_RETRY_PIN_CONFIG_DEFINES_VH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define CMD_OV_WARN_RESPONSE 8'hc4
`define CMD_SPARE_PIN_CONFIG 8'hc5
`define CMD_RC_THRESHOLD 8'hc6

// ------------------------------------------------------------
// response register fields
// ------------------------------------------------------------
`define RESP_MODE_HI 7
`define RESP_MODE_LO 6
`define RESP_RETRY_HI 5
`define RESP_RETRY_LO 3
`define RESP_DELAY_HI 2
`define RESP_DELAY_LO 0
`define MODE_IGNORE 2'h0
`define MODE_RIDE 2'h1
`define MODE_DISABLE_RETRY 2'h2
`define MODE_LATCH_OFF 2'h3
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RESP_RESET 8'h00
`define PIN_CONFIG_RESET 16'h0000
`define RC_THRESHOLD_RESET 8'h00

// ------------------------------------------------------------
// timing: unit times and clock rate
// ------------------------------------------------------------
`define CLK_HZ 100000000
`define UNIT_1MS_US 1000
`define UNIT_10MS_US 10000
`define UNIT_100MS_US 100000
`define UNIT_1S_US 1000000
`define US_PER_S 1000000

`endif

// File: test/fault_retry_pin_config_assertions.sv
// port checks for the fault retry and spare pin block
`timescale 1ns/10ps
`default_nettype none
module fault_retry_pin_config_assertions (
	input wire logic mclk,
	input wire logic rst,
	input wire logic cmdRead,
	input wire logic rdValid_ff,
	input wire logic statusClear,
	input wire logic clearFaults,
	input wire logic operationOn,
	input wire logic biasGood,
	input wire logic outputEnable_ff,
	input wire logic faultLatched_ff,
	input wire logic [2:0] attemptCount_ff,
	input wire logic [7:0] pinOut_ff,
	input wire logic [7:0] funcPinIn_ff,
	input wire logic [7:0] pinUnused_ff,
	input wire logic rcFromAnalog,
	input wire logic remoteTrip_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// causes allowed to drop the count; the clear may land one cycle late
	wire logic clrCause = clearFaults | statusClear | !operationOn | !biasGood;
	// -----------------------------------------------
	// sequences
	// -----------------------------------------------
	sequence s_read;
		cmdRead ##1 rdValid_ff;
	endsequence
	// two quiet cycles so a config change has reached every pin stage
	sequence s_cfgQuiet;
		$stable(pinUnused_ff) [*2];
	endsequence
	// -----------------------------------------------
	// properties
	// -----------------------------------------------
	chk_read_answer: assert property (cmdRead |-> s_read)
		else $error("read not answered");
	chk_valid_pulse: assert property (!cmdRead |=> !rdValid_ff)
		else $error("stray read valid");
	chk_trip_gate: assert property (!rcFromAnalog |=> !remoteTrip_ff)
		else $error("trip without analog source");
	chk_unused_low: assert property (s_cfgQuiet |-> (pinOut_ff & pinUnused_ff) == 8'h00)
		else $error("unused pin driven high");
	chk_unused_in: assert property (s_cfgQuiet |-> (funcPinIn_ff & pinUnused_ff) == 8'h00)
		else $error("unused pin reaches function");
	chk_hold_off: assert property (faultLatched_ff |-> !outputEnable_ff)
		else $error("output on while latched");
	chk_turn_off: assert property ((!biasGood || !operationOn) |=>
		!outputEnable_ff && attemptCount_ff == 3'h0)
		else $error("turn off not obeyed");
	chk_count_drop: assert property (attemptCount_ff < $past(attemptCount_ff) |->
		$past(clrCause) || $past(clrCause, 2))
		else $error("count dropped without clear");
	chk_restart_rise: assert property (attemptCount_ff > $past(attemptCount_ff) |->
		$rose(outputEnable_ff))
		else $error("attempt without restart");
endmodule // fault_retry_pin_config_assertions
`default_nettype wire

// File: test/pmbus_host_model.sv
// host model issuing register commands
`timescale 1ns/10ps
`default_nettype none
module pmbus_host_model (
	input wire logic mclk,
	output logic cmdWrite,
	output logic cmdRead,
	output logic [7:0] cmdCode,
	output logic [15:0] cmdWrData,
	input wire logic [15:0] rdData_ff,
	input wire logic rdValid_ff
);
	// idle code and data show the inverse of the last value, never a stale match
	initial begin
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdCode = 8'h00;
		cmdWrData = 16'h0000;
	end
	// one-cycle strobe; read data is taken in the cycle after the strobe edge,
	// while the valid pulse stands, since it drops again at the next edge
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge mclk);
		#1;
		cmdCode = c;
		cmdWrData = d;
		cmdWrite = w;
		cmdRead = !w;
		@(posedge mclk);
		#1;
		if (!w) begin
			q = rdValid_ff ? rdData_ff : 16'hxxxx;
		end
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdCode = ~c;
		cmdWrData = ~d;
	endtask
endmodule // pmbus_host_model
`default_nettype wire

// File: test/testbench.sv
// self-checking bench for the fault retry and spare pin block
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic cmdWrite, cmdRead, rdValid_ff, faultIn, statusClear, clearFaults, operationOn;
	logic biasGood, otherShutdown, outputEnable_ff, faultLatched_ff, rcFromAnalog, remoteTrip_ff;
	logic [1:0] unitSelect;
	logic [2:0] attemptCount_ff;
	logic [7:0] cmdCode, funcPinOut, funcPinOe, pinIn, pinOut_ff, pinOe_ff, funcPinIn_ff;
	logic [7:0] pinUnused_ff, analogLevel;
	logic [15:0] cmdWrData, rdData_ff, rd, cfg;
	logic [31:0] seed;
	int i, n, t, err_count, n_checks;
	pmbus_host_model host_u (.mclk, .cmdWrite, .cmdRead, .cmdCode, .cmdWrData, .rdData_ff,
		.rdValid_ff);
	fault_retry_pin_config #(.UNIT_1MS_CYC(32'd4), .UNIT_10MS_CYC(32'd8),
		.UNIT_100MS_CYC(32'd16), .UNIT_1S_CYC(32'd32)) dut_u (.mclk, .rst, .cmdWrite,
		.cmdRead, .cmdCode, .cmdWrData, .rdData_ff, .rdValid_ff, .unitSelect, .faultIn,
		.statusClear, .clearFaults, .operationOn, .biasGood, .otherShutdown,
		.outputEnable_ff, .faultLatched_ff, .attemptCount_ff, .funcPinOut, .funcPinOe,
		.pinIn, .pinOut_ff, .pinOe_ff, .funcPinIn_ff, .pinUnused_ff, .rcFromAnalog,
		.analogLevel, .remoteTrip_ff);
	// 100 MHz clock
	always #5 mclk = ~mclk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	// new response setting, then an off-on cycle so old state is gone
	task automatic arm(input logic [7:0] r, input logic [1:0] u);
		faultIn = 1'b0;
		unitSelect = u;
		host_u.xfer(1'b1, 8'hc4, {8'h00, r}, rd);
		operationOn = 1'b0;
		tick(2);
		operationOn = 1'b1;
		tick(4);
		chk(outputEnable_ff, 1'b1);
		faultIn = 1'b1;
	endtask
	task automatic waitHold;
		for (n = 0; faultLatched_ff !== 1'b1 && n < 6000; n++) tick(1);
	endtask
	// watchdog at 50k cycles, well past the under 10k cycles the tests need
	initial begin
		#500000;
		err_count++;
		give_verdict;
	end
	// main sequence
	initial begin
		{faultIn, statusClear, clearFaults, otherShutdown, rcFromAnalog} = 5'h00;
		{operationOn, biasGood, unitSelect} = 4'hc;
		{funcPinOut, funcPinOe, pinIn, analogLevel} = 32'h00000000;
		seed = 32'h6a25a64c;
		err_count = 0;
		n_checks = 0;
		tick(6);
		rst = 1'b0;
		for (i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			host_u.xfer(1'b1, 8'hc4 + i[7:0], seed[15:0], rd);
			host_u.xfer(1'b0, 8'hc4 + i[7:0], 16'h0000, rd);
			chk(rd, (i == 1) ? seed[15:0] : {8'h00, seed[7:0]});
		end
		host_u.xfer(1'b0, 8'h3b, 16'h0000, rd);
		chk(rd, 16'h0000);
		$display("registers done");
		// first corner: every pin unused and driven low, none grounded on board
		for (i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			cfg = (i == 0) ? 16'hffff : (i == 1) ? 16'h00ff : seed[15:0];
			host_u.xfer(1'b1, 8'hc5, cfg, rd);
			{funcPinOut, funcPinOe, pinIn} = seed[31:8];
			tick(4);
			chk(pinUnused_ff, cfg[7:0]);
			chk(pinOe_ff, cfg[15:8] & cfg[7:0] | funcPinOe & ~cfg[7:0]);
			chk(pinOut_ff, funcPinOut & ~cfg[7:0]);
			chk(funcPinIn_ff, pinIn & ~cfg[7:0]);
		end
		$display("pins done");
		host_u.xfer(1'b1, 8'hc6, seed[15:0], rd);
		for (i = 0; i < 12; i++) begin
			rcFromAnalog = (i < 2) | seed[20];
			analogLevel = (i < 2) ? seed[7:0] - i[7:0] : seed[30:23];
			tick(1);
			chk(remoteTrip_ff, rcFromAnalog && analogLevel >= seed[7:0]);
			seed = (lfsr(seed) & 32'hffffff00) | (seed & 32'h000000ff);
		end
		$display("threshold done");
		for (i = 0; i < 7; i++) begin
			arm({2'h2, i[2:0], 3'h0}, 2'h0);
			waitHold;
			chk(attemptCount_ff, i[2:0]);
			chk(outputEnable_ff, 1'b0);
		end
		for (i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			arm({5'h11, i[2:0]}, seed[1:0]);
			tick(2);
			for (n = 0; outputEnable_ff !== 1'b1 && n < 6000; n++) tick(1);
			t = (4 << seed[1:0]) << i;
			chk(n >= t - 2 && n <= t + 3, 1'b1);
		end
		$display("retry done");
		arm(8'h53, 2'h1);
		tick(40);
		chk(outputEnable_ff, 1'b1);
		waitHold;
		chk(attemptCount_ff, 3'h2);
		arm(8'h53, 2'h0);
		tick(10);
		faultIn = 1'b0;
		tick(40);
		chk({outputEnable_ff, faultLatched_ff, attemptCount_ff}, 5'h10);
		arm(8'he8, 2'h0);
		tick(3);
		chk({faultLatched_ff, attemptCount_ff}, 4'h8);
		arm(8'h28, 2'h0);
		tick(50);
		chk({outputEnable_ff, faultLatched_ff}, 2'h2);
		arm(8'hb8, 2'h0);
		tick(300);
		chk({faultLatched_ff, attemptCount_ff}, 4'h7);
		otherShutdown = 1'b1;
		tick(1);
		otherShutdown = 1'b0;
		tick(2);
		chk(faultLatched_ff, 1'b1);
		$display("modes done");
		for (i = 0; i < 4; i++) begin
			arm(8'h88, 2'h0);
			waitHold;
			faultIn = 1'b0;
			{clearFaults, statusClear, operationOn, biasGood} = 4'h3 ^ (4'h8 >> i);
			tick(1);
			{clearFaults, statusClear, operationOn, biasGood} = 4'h3;
			tick(4);
			chk({faultLatched_ff, attemptCount_ff}, 4'h0);
		end
		$display("clear done");
		give_verdict;
	end
endmodule // testbench
bind fault_retry_pin_config fault_retry_pin_config_assertions chk_u (.mclk, .rst, .cmdRead,
	.rdValid_ff, .statusClear, .clearFaults, .operationOn, .biasGood, .outputEnable_ff,
	.faultLatched_ff, .attemptCount_ff, .pinOut_ff, .funcPinIn_ff, .pinUnused_ff,
	.rcFromAnalog, .remoteTrip_ff);
`default_nettype wire
